// ==== pkg/nvm_link_if.sv ====
// signal bundle between the register block and its two helper modules
// assumes the helper modules run on the same clock as the register block
interface nvm_link_if;
	import nvm_opt_pkg::*;

	// protection lookup
	logic [7:0] prot_value;
	logic [15:0] chk_addr;
	logic chk_eeprom;
	logic chk_hit;
	logic any_prot;

	// backdoor key comparison
	logic key_wr;
	logic [2:0] key_idx;
	logic [7:0] key_data;
	logic key_unlock;

	modport top (output prot_value, output chk_addr, output chk_eeprom, input chk_hit, input any_prot,
		output key_wr, output key_idx, output key_data, input key_unlock);
	modport prot (input prot_value, input chk_addr, input chk_eeprom, output chk_hit, output any_prot);
	modport key (input key_wr, input key_idx, input key_data, output key_unlock);
endinterface

// ==== pkg/nvm_opt_pkg.sv ====
// constants, types and helper functions for the option and protection register block
// assumes one bus clock and a synchronous active-low reset in every user
package nvm_opt_pkg;

	// ---------------------------------------------------------------
	// register offsets on the plain register port
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_OPTIONS = 4'h0;
	localparam logic [3:0] OFS_CONFIG = 4'h1;
	localparam logic [3:0] OFS_PROTECTION = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;

	// ---------------------------------------------------------------
	// field layouts and reset values
	// ---------------------------------------------------------------
	localparam int OPT_BACKDOOR_BIT = 7;
	localparam int OPT_NORED_BIT = 6;
	localparam int OPT_SECTOR_MODE_BIT = 5;
	localparam logic [7:0] OPT_MASK = 8'he3;
	localparam logic [1:0] CODE_UNSECURED = 2'h2;
	localparam int CFG_PAGE_BIT = 6;
	localparam int CFG_KEY_WRITE_BIT = 5;
	localparam logic [7:0] CFG_MASK = 8'h60;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int STAT_VIOL_BIT = 5;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ---------------------------------------------------------------
	// key window and protection geometry
	// ---------------------------------------------------------------
	localparam logic [15:0] KEY_BASE = 16'hffb0;
	localparam logic [3:0] KEY_LEN = 4'h8;
	localparam logic [12:0] KEY_WINDOW_TAG = 13'h1ff6;
	localparam logic [5:0] FPS_NONE = 6'h3f;
	localparam logic [5:0] FPS_ALL_MAX = 6'h18;
	localparam logic [5:0] FPS_ALL_STEPS = 6'h27;
	localparam logic [16:0] FLASH_TOP = 17'h10000;
	localparam logic [16:0] FLASH_STEP = 17'h00600;
	localparam logic [1:0] EPS_NONE = 2'h3;
	localparam logic [15:0] EE_TOP = 16'h1800;
	localparam logic [15:0] EE_SPAN_MAX = 16'h0040;

	// command kinds offered by the command logic outside
	typedef enum logic [1:0] {
		CMD_PROGRAM = 2'h0,
		CMD_SECTOR_ERASE = 2'h1,
		CMD_MASS_ERASE = 2'h2
	} cmd_kind_e;

	// flash protection size in steps of 1.5K, larger means more protected
	function automatic logic [5:0] flash_steps(input logic [5:0] fps);
		flash_steps = (fps <= FPS_ALL_MAX) ? FPS_ALL_STEPS : (FPS_NONE - fps);
	endfunction

	// eeprom protection size in steps, larger means more protected
	function automatic logic [1:0] ee_steps(input logic [1:0] eps);
		ee_steps = EPS_NONE - eps;
	endfunction

	// true when the new protection byte covers at least the old region in both fields
	function automatic logic prot_grows(input logic [7:0] old_v, input logic [7:0] new_v);
		prot_grows = (flash_steps(new_v[5:0]) >= flash_steps(old_v[5:0])) &&
			(ee_steps(new_v[7:6]) >= ee_steps(old_v[7:6]));
	endfunction

endpackage

// ==== rtl/key_compare.sv ====
// backdoor key comparator: checks eight key bytes written in ascending order
// assumes the caller passes only writes that are allowed to take part
module key_compare
	import nvm_opt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [63:0] stored_backdoor_key,
	nvm_link_if.key lnk
);

	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic ok_r;
	logic ok_nxt;
	logic unlock_r;

	// ---------------------------------------------------------------
	// sequence tracking
	// ---------------------------------------------------------------
	// a write to the first key byte always restarts, so a botched attempt can be retried
	wire [7:0] ref_byte = stored_backdoor_key[{lnk.key_idx, 3'h0} +: 8];
	wire byte_match = (lnk.key_data == ref_byte);
	wire restart = (lnk.key_idx == 3'h0);
	wire in_order = ({1'b0, lnk.key_idx} == cnt_r);
	wire last_byte = (cnt_r == KEY_LEN - 4'h1) && in_order;
	assign cnt_nxt = restart ? 4'h1 : (in_order ? 4'(cnt_r + 4'h1) : 4'h0);
	assign ok_nxt = restart ? byte_match : (in_order && ok_r && byte_match);

	// counter, running match and the one-cycle unlock pulse
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_r <= 4'h0;
			ok_r <= 1'b0;
			unlock_r <= 1'b0;
		end else begin
			unlock_r <= lnk.key_wr && last_byte && ok_nxt; // RULE3
			if (lnk.key_wr) begin
				cnt_r <= last_byte ? 4'h0 : cnt_nxt;
				ok_r <= ok_nxt;
			end
		end
	end

	assign lnk.key_unlock = unlock_r;

endmodule

// ==== rtl/nvm_option_protect_regs.sv ====
// option, configuration and protection registers of the flash and eeprom controller
// assumes nonvolatile option and protection bytes are valid while reset is held,
// and that the command sequencer outside reports launches and blank-check results
//
// Functional notes
// RULE1: option register reloads from option byte each reset
// RULE2: backdoor disabled means key never unlocks
// RULE3: eight matching ascending key bytes unsecure
// RULE4: key writes from debug interface refused
// RULE5: redirect disable bit turns off vector redirection
// RULE6: sector mode bit selects split or whole sectors
// RULE7: only security code 1:0 means unsecured
// RULE8: secure state blocks unsecured sources from memory
// RULE9: key unlock or blank check sets 1:0
// RULE10: page select bit picks foreground eeprom page
// RULE11: key access bit steers window writes
// RULE12: protection register loads from protection byte at reset
// RULE13: protection readable, writes may only grow region
// RULE14: protected program or erase sets violation flag
// RULE15: mass erase refused while anything protected
// RULE16: debug interface may rewrite protection freely
// RULE17: software reprograms option byte, then resets
// RULE18: software unprotects and erases before reprogramming
// RULE19: split mode sector erase clears both halves
// RULE20: violating command is discarded
// RULE21: undocumented option bits read zero
module nvm_option_protect_regs
	import nvm_opt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_from_debug,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] nonvolatile_option_byte,
	input wire logic [7:0] nonvolatile_protection_byte,
	input wire logic [63:0] stored_backdoor_key,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr_debug,
	output logic flash_write_start,
	input wire logic mem_req,
	input wire logic mem_req_unsecured,
	output logic mem_grant,
	input wire logic cmd_launch,
	input wire logic [1:0] cmd_kind,
	input wire logic [15:0] cmd_addr,
	input wire logic cmd_eeprom,
	output logic cmd_go,
	output logic cmd_both_pages,
	input wire logic blank_check_ok,
	output logic secure,
	output logic backdoor_enable,
	output logic vector_redirect_disable,
	output logic eeprom_sector_mode,
	output logic eeprom_page_select
);

	nvm_link_if lnk ();

	logic [7:0] options_r;
	logic [7:0] config_r;
	logic [7:0] config_nxt;
	logic [7:0] protection_r;
	logic [7:0] protection_nxt;
	logic viol_r;
	logic viol_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic go_r;
	logic both_r;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	prot_check u_prot (
		.lnk(lnk.prot)
	);

	key_compare u_key (
		.mclk(mclk),
		.rst_n(rst_n),
		.stored_backdoor_key(stored_backdoor_key),
		.lnk(lnk.key)
	);

	// ---------------------------------------------------------------
	// register decode
	// ---------------------------------------------------------------
	// one compare per register, shared by the write and the read path
	function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
		reg_hit = (addr == ofs);
	endfunction

	wire sel_options = reg_hit(reg_addr, OFS_OPTIONS);
	wire sel_config = reg_hit(reg_addr, OFS_CONFIG);
	wire sel_prot = reg_hit(reg_addr, OFS_PROTECTION);
	wire sel_status = reg_hit(reg_addr, OFS_STATUS);
	wire wr_config = reg_wr && sel_config;
	wire wr_prot = reg_wr && sel_prot;
	wire wr_status = reg_wr && sel_status;
	wire prot_ok = reg_from_debug || prot_grows(protection_r, reg_wdata); // RULE13 RULE16
	wire viol_clear = wr_status && reg_wdata[STAT_VIOL_BIT];

	assign config_nxt = wr_config ? (reg_wdata & CFG_MASK) : config_r;
	assign protection_nxt = (wr_prot && prot_ok) ? reg_wdata : protection_r; // RULE13

	// read mux; the options register is read-only and ignores writes
	wire [7:0] status_view = {2'h0, viol_r, 5'h00};
	assign rdata_nxt = !reg_rd ? BYTE_ZERO :
		sel_options ? options_r :
		sel_config ? config_r :
		sel_prot ? protection_r : // RULE13
		sel_status ? status_view : BYTE_ZERO;

	// ---------------------------------------------------------------
	// option field decode
	// ---------------------------------------------------------------
	assign secure = (options_r[1:0] != CODE_UNSECURED); // RULE7
	assign backdoor_enable = options_r[OPT_BACKDOOR_BIT];
	assign vector_redirect_disable = options_r[OPT_NORED_BIT]; // RULE5
	assign eeprom_sector_mode = options_r[OPT_SECTOR_MODE_BIT]; // RULE6
	assign eeprom_page_select = config_r[CFG_PAGE_BIT]; // RULE10

	// memory access gate for sources outside the trusted firmware
	assign mem_grant = mem_req && !(secure && mem_req_unsecured); // RULE8

	// ---------------------------------------------------------------
	// key window steering
	// ---------------------------------------------------------------
	// a debug write in the window with key access set is simply dropped, it is no command either
	wire in_window = (mem_addr[15:3] == KEY_WINDOW_TAG);
	wire key_write_enable = config_r[CFG_KEY_WRITE_BIT];
	assign flash_write_start = mem_wr && in_window && !key_write_enable; // RULE11
	assign lnk.key_wr = mem_wr && in_window && key_write_enable && !mem_wr_debug && backdoor_enable; // RULE2 RULE4 RULE11
	assign lnk.key_idx = mem_addr[2:0];
	assign lnk.key_data = mem_wdata;

	// ---------------------------------------------------------------
	// command screening
	// ---------------------------------------------------------------
	assign lnk.prot_value = protection_r;
	assign lnk.chk_addr = cmd_addr;
	assign lnk.chk_eeprom = cmd_eeprom;
	wire mass = (cmd_kind == CMD_MASS_ERASE);
	wire cmd_bad = lnk.chk_hit || (mass && lnk.any_prot); // RULE14 RULE15
	wire sector_split = (cmd_kind == CMD_SECTOR_ERASE) && cmd_eeprom && !eeprom_sector_mode;
	// the flag is sticky; a new violation in the clearing cycle wins
	assign viol_nxt = (cmd_launch && cmd_bad) ? 1'b1 : (viol_clear ? 1'b0 : viol_r); // RULE14

	// ---------------------------------------------------------------
	// option register: copied during reset, only the security code moves later
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			options_r <= nonvolatile_option_byte & OPT_MASK; // RULE1 RULE21
		end else if (lnk.key_unlock || blank_check_ok) begin
			options_r[1:0] <= CODE_UNSECURED; // RULE9
		end
	end

	// protection register: loaded from the nonvolatile byte while reset is held
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			protection_r <= nonvolatile_protection_byte; // RULE12
		end else begin
			protection_r <= protection_nxt;
		end
	end

	// configuration, status flag and read data
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			config_r <= CFG_RESET;
			viol_r <= 1'b0;
			rdata_r <= BYTE_ZERO;
		end else begin
			config_r <= config_nxt;
			viol_r <= viol_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// accepted command pulse; a bad command never reaches the array
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			go_r <= 1'b0;
			both_r <= 1'b0;
		end else begin
			go_r <= cmd_launch && !cmd_bad; // RULE20
			both_r <= cmd_launch && !cmd_bad && sector_split; // RULE19
		end
	end

	assign reg_rdata = rdata_r;
	assign cmd_go = go_r;
	assign cmd_both_pages = both_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_OPT_LOAD: assert property ($rose(rst_n) |-> options_r == ($past(nonvolatile_option_byte) & OPT_MASK)) // RULE1
		else $error("option register not loaded from option byte at reset");
	AST_PROT_LOAD: assert property ($rose(rst_n) |-> protection_r == $past(nonvolatile_protection_byte)) // RULE12
		else $error("protection register not loaded at reset");
	AST_KEY_DISABLED: assert property (!backdoor_enable |-> ##1 !lnk.key_unlock) // RULE2
		else $error("key unlock while backdoor disabled");
	AST_KEY_DEBUG: assert property (mem_wr && mem_wr_debug |-> !lnk.key_wr) // RULE4
		else $error("debug write reached key comparator");
	AST_UNLOCK: assert property (lnk.key_unlock |=> !secure) // RULE3
		else $error("security still engaged after key unlock");
	AST_BLANK: assert property (blank_check_ok |=> options_r[1:0] == CODE_UNSECURED) // RULE9
		else $error("blank check did not unsecure");
	AST_SEC_HOLD: assert property (!secure && !$past(blank_check_ok) && !$past(lnk.key_unlock) |-> !$past(secure)) // RULE7
		else $error("security code changed without cause");
	AST_GATE: assert property (secure && mem_req && mem_req_unsecured |-> !mem_grant) // RULE8
		else $error("unsecured source granted while secure");
	AST_STEER: assert property (mem_wr && in_window |-> (flash_write_start != key_write_enable)) // RULE11
		else $error("key window write steered wrongly");
	AST_SHRINK: assert property (wr_prot && !reg_from_debug && !prot_grows(protection_r, reg_wdata)
		|=> $stable(protection_r)) // RULE13
		else $error("protection region shrank");
	AST_DEBUG_PROT: assert property (wr_prot && reg_from_debug |=> protection_r == $past(reg_wdata)) // RULE16
		else $error("debug write to protection lost");
	AST_VIOL: assert property (cmd_launch && lnk.chk_hit |=> viol_r && !cmd_go) // RULE14 RULE20
		else $error("protected command not flagged or not discarded");
	AST_MASS: assert property (cmd_launch && mass && lnk.any_prot |=> !cmd_go && viol_r) // RULE15
		else $error("mass erase accepted with protection");
	AST_SPLIT: assert property (cmd_launch && !cmd_bad && sector_split |=> cmd_go && cmd_both_pages) // RULE19
		else $error("split sector erase not spanning both halves");

	COV_UNLOCK: cover property (lnk.key_unlock ##1 !secure);
	COV_VIOL: cover property (cmd_launch && cmd_bad ##1 viol_r);
	COV_GROW: cover property (wr_prot && !reg_from_debug && prot_ok ##1 $changed(protection_r));
	COV_START: cover property (flash_write_start);
	COV_SPLIT: cover property (cmd_both_pages);

	// ---------------------------------------------------------------
	// assertions: register contents and read path
	// ---------------------------------------------------------------
	// unused bits must never leak into software reads
	AST_OPT_ZERO: assert property ((options_r & ~OPT_MASK) == BYTE_ZERO) // RULE21
		else $error("undocumented option bit set");
	AST_OPT_STILL: assert property (!$past(lnk.key_unlock) && !$past(blank_check_ok) |-> $stable(options_r)) // RULE1
		else $error("option register moved between resets");
	AST_CFG_ZERO: assert property ((config_r & ~CFG_MASK) == BYTE_ZERO) // RULE10 RULE11
		else $error("unused configuration bit set");
	AST_PAGE: assert property (wr_config |=> eeprom_page_select == $past(reg_wdata[CFG_PAGE_BIT])) // RULE10
		else $error("page select not taken from write");
	AST_PROT_READ: assert property (reg_rd && sel_prot |=> reg_rdata == $past(protection_r)) // RULE13
		else $error("protection register not readable");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == BYTE_ZERO) // RULE13
		else $error("read data standing without a read");
	AST_GROW: assert property (wr_prot && prot_grows(protection_r, reg_wdata)
		|=> protection_r == $past(reg_wdata)) // RULE13
		else $error("growing protection write lost");

	// ---------------------------------------------------------------
	// assertions: commands, status flag, access gate and key window
	// ---------------------------------------------------------------
	// a violation in the clearing cycle must survive, or software would miss it
	AST_VIOL_WINS: assert property (cmd_launch && cmd_bad && viol_clear |=> viol_r) // RULE14
		else $error("violation lost to a clear in the same cycle");
	AST_VIOL_CLR: assert property (viol_clear && !(cmd_launch && cmd_bad) |=> !viol_r) // RULE14
		else $error("violation flag not cleared by writing one");
	AST_GO: assert property (cmd_launch && !cmd_bad |=> cmd_go) // RULE20
		else $error("clean command not passed on");
	AST_IDLE: assert property (!cmd_launch |=> !cmd_go && !cmd_both_pages) // RULE20
		else $error("command pulse without a launch");
	AST_WHOLE: assert property (cmd_launch && eeprom_sector_mode |=> !cmd_both_pages) // RULE6
		else $error("whole-sector mode erased the hidden page");
	AST_BOTH_GO: assert property (cmd_both_pages |-> cmd_go) // RULE19
		else $error("both-page erase without an accepted command");
	AST_FREE: assert property (mem_req && !secure |-> mem_grant) // RULE8
		else $error("request refused while unsecured");
	AST_UNLOCK_EN: assert property (lnk.key_unlock |-> backdoor_enable) // RULE2
		else $error("key unlock with backdoor disabled");
	AST_START_ONLY: assert property (flash_write_start |-> !lnk.key_wr && !key_write_enable) // RULE11
		else $error("window write both started a command and compared a key");

endmodule

// ==== rtl/prot_check.sv ====
// protection range lookup: tells whether an address lies in a protected block
// assumes eeprom command addresses arrive as absolute memory-map addresses
module prot_check
	import nvm_opt_pkg::*;
(
	nvm_link_if.prot lnk
);

	// ---------------------------------------------------------------
	// flash range: the protected area always ends at the top of memory
	// ---------------------------------------------------------------
	wire [5:0] fps = lnk.prot_value[5:0];
	wire [1:0] eps = lnk.prot_value[7:6];
	wire [16:0] flash_span = 17'(flash_steps(fps) * FLASH_STEP);
	wire [16:0] flash_limit = (fps <= FPS_ALL_MAX) ? 17'h00000 : 17'(FLASH_TOP - flash_span);
	wire flash_hit = (fps != FPS_NONE) && ({1'b0, lnk.chk_addr} >= flash_limit);

	// eeprom range: each step down halves nothing, it doubles the span
	wire [15:0] ee_limit = EE_TOP - (EE_SPAN_MAX >> eps);
	wire ee_hit = (eps != EPS_NONE) && (lnk.chk_addr >= ee_limit) && (lnk.chk_addr < EE_TOP);

	assign lnk.chk_hit = lnk.chk_eeprom ? ee_hit : flash_hit;
	assign lnk.any_prot = (fps != FPS_NONE) || (eps != EPS_NONE);

endmodule

// ==== sim/nvm_option_protect_regs_tb.sv ====
// self-checking testbench for the option, configuration and protection register block
// assumes the design package offsets and a read answer registered one cycle after the strobe
module nvm_option_protect_regs_tb
	import nvm_opt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_from_debug = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] nv_opt = 8'hff;
	logic [7:0] nv_prot = 8'hbe;
	logic [63:0] key = 64'h8877665544332211;
	logic mem_wr = 1'b0;
	logic [15:0] mem_addr = 16'h0000;
	logic [7:0] mem_wdata = 8'h00;
	logic mem_wr_debug = 1'b0;
	logic flash_write_start;
	logic mem_req = 1'b0;
	logic mem_req_unsecured = 1'b0;
	logic mem_grant;
	logic cmd_launch = 1'b0;
	logic [1:0] cmd_kind = 2'h0;
	logic [15:0] cmd_addr = 16'h0000;
	logic cmd_eeprom = 1'b0;
	logic cmd_go;
	logic cmd_both_pages;
	logic blank_check_ok = 1'b0;
	logic secure;
	logic backdoor_enable;
	logic vector_redirect_disable;
	logic eeprom_sector_mode;
	logic eeprom_page_select;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;

	// 100 ns period
	always #50 mclk = ~mclk;

	nvm_option_protect_regs uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_from_debug(reg_from_debug), .reg_rdata(reg_rdata),
		.nonvolatile_option_byte(nv_opt), .nonvolatile_protection_byte(nv_prot), .stored_backdoor_key(key),
		.mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr_debug(mem_wr_debug),
		.flash_write_start(flash_write_start), .mem_req(mem_req), .mem_req_unsecured(mem_req_unsecured),
		.mem_grant(mem_grant), .cmd_launch(cmd_launch), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_eeprom(cmd_eeprom), .cmd_go(cmd_go), .cmd_both_pages(cmd_both_pages),
		.blank_check_ok(blank_check_ok), .secure(secure), .backdoor_enable(backdoor_enable),
		.vector_redirect_disable(vector_redirect_disable), .eeprom_sector_mode(eeprom_sector_mode),
		.eeprom_page_select(eeprom_page_select));

	// ---------------------------------------------------------------
	// reporting
	// ---------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// hang guard: the whole sequence needs well under 1500 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			complete_run();
		end
	end

	// ---------------------------------------------------------------
	// access tasks, all driving right after a rising edge
	// ---------------------------------------------------------------
	// reset held 20 cycles so the nonvolatile bytes are sampled many times
	task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
		@(posedge mclk);
		rst_n <= 1'b0;
		nv_opt <= opt;
		nv_prot <= prot;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d, input logic dbg);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_from_debug <= dbg;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_from_debug <= 1'b0;
		#1;
	endtask

	// read data is only valid in the cycle after the strobe, so sample just after that edge
	task automatic reg_read(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp, input string msg);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & mask, exp, msg);
	endtask

	// eight key window writes in ascending order; bad corrupts the fourth byte
	task automatic key_seq(input logic dbg, input logic bad, input logic exp_start);
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			mem_wr <= 1'b1;
			mem_addr <= KEY_BASE + 16'(i);
			mem_wdata <= key[8*i +: 8] ^ ((bad && i == 3) ? 8'h01 : 8'h00);
			mem_wr_debug <= dbg;
			#1;
			chk(flash_write_start, exp_start, "window write steering");
			@(posedge mclk);
			mem_wr <= 1'b0;
		end
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task automatic cmd(input logic [1:0] kind, input logic [15:0] a, input logic ee, input logic go,
		input logic both);
		@(posedge mclk);
		cmd_launch <= 1'b1;
		cmd_kind <= kind;
		cmd_addr <= a;
		cmd_eeprom <= ee;
		@(posedge mclk);
		cmd_launch <= 1'b0;
		#1;
		chk(cmd_go, go, "command accepted");
		chk(cmd_both_pages, both, "both pages erased");
	endtask

	task automatic grant(input logic unsec, input logic exp);
		@(posedge mclk);
		mem_req <= 1'b1;
		mem_req_unsecured <= unsec;
		#1;
		chk(mem_grant, exp, "memory grant");
		@(posedge mclk);
		mem_req <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		do_reset(8'hff, 8'hbe);
		reg_read(OFS_OPTIONS, 8'hff, 8'he3, "options after reset");
		chk(backdoor_enable, 1'b1, "backdoor enable");
		chk(vector_redirect_disable, 1'b1, "redirect disable");
		chk(eeprom_sector_mode, 1'b1, "sector mode");
		chk(secure, 1'b1, "secure with code 1:1");
		reg_read(OFS_PROTECTION, 8'hff, 8'hbe, "protection after reset");
		$display("test reset_load done");

		reg_write(OFS_OPTIONS, 8'h00, 1'b0);
		reg_read(OFS_OPTIONS, 8'hff, 8'he3, "options write ignored");
		reg_write(OFS_CONFIG, 8'hff, 1'b0);
		reg_read(OFS_CONFIG, 8'hff, 8'h60, "config readback");
		chk(eeprom_page_select, 1'b1, "page 1 selected");
		reg_write(OFS_CONFIG, 8'h00, 1'b0);
		chk(eeprom_page_select, 1'b0, "page 0 selected");
		reg_read(4'hf, 8'hff, 8'h00, "unmapped read");
		$display("test registers done");

		grant(1'b1, 1'b0);
		grant(1'b0, 1'b1);
		key_seq(1'b0, 1'b0, 1'b1);
		chk(secure, 1'b1, "window writes as command start");
		reg_write(OFS_CONFIG, 8'h20, 1'b0);
		key_seq(1'b1, 1'b0, 1'b0);
		chk(secure, 1'b1, "debug key refused");
		key_seq(1'b0, 1'b1, 1'b0);
		chk(secure, 1'b1, "wrong key refused");
		key_seq(1'b0, 1'b0, 1'b0);
		chk(secure, 1'b0, "right key unsecures");
		reg_read(OFS_OPTIONS, 8'hff, 8'he2, "code after key");
		grant(1'b1, 1'b1);
		$display("test security done");

		cmd(CMD_PROGRAM, 16'hfc00, 1'b0, 1'b0, 1'b0);
		reg_read(OFS_STATUS, 8'h20, 8'h20, "violation set");
		reg_write(OFS_STATUS, 8'h20, 1'b0);
		reg_read(OFS_STATUS, 8'h20, 8'h00, "violation cleared");
		cmd(CMD_PROGRAM, 16'h8000, 1'b0, 1'b1, 1'b0);
		cmd(CMD_MASS_ERASE, 16'h8000, 1'b0, 1'b0, 1'b0);
		cmd(CMD_SECTOR_ERASE, 16'h17f8, 1'b1, 1'b0, 1'b0);
		cmd(CMD_SECTOR_ERASE, 16'h1700, 1'b1, 1'b1, 1'b0);
		$display("test commands done");

		// shrink attempts from software must leave the region as it was
		reg_write(OFS_PROTECTION, 8'hff, 1'b0);
		reg_read(OFS_PROTECTION, 8'hff, 8'hbe, "shrink ignored");
		reg_write(OFS_PROTECTION, 8'h7d, 1'b0);
		reg_read(OFS_PROTECTION, 8'hff, 8'h7d, "grow accepted");
		reg_write(OFS_PROTECTION, 8'hbe, 1'b0);
		reg_read(OFS_PROTECTION, 8'hff, 8'h7d, "partial shrink ignored");
		reg_write(OFS_PROTECTION, 8'hff, 1'b1);
		reg_read(OFS_PROTECTION, 8'hff, 8'hff, "debug write accepted");
		cmd(CMD_MASS_ERASE, 16'h0000, 1'b0, 1'b1, 1'b0);
		$display("test protection done");

		// every security code decoded through a fresh reset
		for (int c = 0; c < 4; c++) begin
			do_reset({6'h00, 2'(c)}, 8'hff);
			chk(secure, {7'h00, (c != 2)}, "security decode");
		end
		do_reset(8'h41, 8'hff);
		reg_read(OFS_OPTIONS, 8'hff, 8'h41, "options reloaded");
		chk(backdoor_enable, 1'b0, "backdoor off");
		chk(vector_redirect_disable, 1'b1, "redirect off");
		chk(eeprom_sector_mode, 1'b0, "split sectors");
		chk(secure, 1'b1, "secure with code 0:1");
		reg_read(OFS_PROTECTION, 8'hff, 8'hff, "protection reloaded");
		reg_write(OFS_CONFIG, 8'h20, 1'b0);
		key_seq(1'b0, 1'b0, 1'b0);
		chk(secure, 1'b1, "key ignored without backdoor");
		@(posedge mclk);
		blank_check_ok <= 1'b1;
		@(posedge mclk);
		blank_check_ok <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(secure, 1'b0, "blank check unsecures");
		reg_read(OFS_OPTIONS, 8'hff, 8'h42, "code after blank check");
		cmd(CMD_SECTOR_ERASE, 16'h1700, 1'b1, 1'b1, 1'b1);
		$display("test reload done");
		complete_run();
	end
endmodule
